// [rtl/overflow_pulse_gen.sv]
`timescale 1ns/100ps

module overflow_pulse_gen
	import port_e_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic overflowFull,
	input  wire logic overflowLow,
	input  wire logic splitMode,
	output logic      pulse
);

	logic srcPrev;
	logic src;

	// split counters report through the low byte
	assign src = splitMode ? overflowLow : overflowFull;

	// ======================================================
	// rising edge of the source gives exactly one cycle high;
	// a held overflow level does not stretch the pulse
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			srcPrev <= 1'h0;
			pulse   <= 1'h0;
		end else begin
			srcPrev <= src;
			pulse   <= src & ~srcPrev;
		end
	end

endmodule

// [rtl/pin_event_if.sv]
`timescale 1ns/100ps

// ==========================================================
// synchronised pin levels and their edges
interface pin_event_if;
	logic [7:0] level;
	logic [7:0] rise;
	logic [7:0] fall;

	modport producer (output level, output rise, output fall);
	modport consumer (input level, input rise, input fall);
endinterface

// [rtl/pin_sync_edge.sv]
`timescale 1ns/100ps

module pin_sync_edge
	import port_e_pkg::*;
(
	input  wire logic  ref_clk,
	input  wire logic  rst,
	input  wire byte_t pinIn,
	pin_event_if.producer ev
);

	byte_t meta;
	byte_t stable;
	byte_t prev;

	// ======================================================
	// two-stage synchroniser, then one history stage per bit
	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					meta[i]   <= 1'h0;
					stable[i] <= 1'h0;
					prev[i]   <= 1'h0;
				end else begin
					meta[i]   <= pinIn[i];
					stable[i] <= meta[i];
					prev[i]   <= stable[i];
				end
			end
		end
	endgenerate

	// edges only look at the second stage and its history stage, never at meta
	assign ev.level = stable;
	assign ev.rise  = stable & ~prev;
	assign ev.fall  = ~stable & prev;

endmodule

// [rtl/port_e_alt_function_mux.sv]
// Decided for this implementation: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "port_e_params.svh"

module port_e_alt_function_mux
	import port_e_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire logic         rst,
	// AXI4-Lite slave
	input  wire logic [7:0]   awaddr,
	input  wire logic         awvalid,
	output logic              awready,
	input  wire logic [31:0]  wdata,
	input  wire logic [3:0]   wstrb,
	input  wire logic         wvalid,
	output logic              wready,
	output logic [1:0]        bresp,
	output logic              bvalid,
	input  wire logic         bready,
	input  wire logic [7:0]   araddr,
	input  wire logic         arvalid,
	output logic              arready,
	output logic [31:0]       rdata,
	output logic [1:0]        rresp,
	output logic              rvalid,
	input  wire logic         rready,
	// port pins
	input  wire byte_t        pinIn,
	output byte_t             pinOut,
	output byte_t             pinOe,
	// internal peripherals, same clock
	input  wire logic         timer0Overflow,
	input  wire logic         timer0LowOverflow,
	input  wire logic         timer0SplitMode,
	input  wire logic         timer1Overflow,
	input  wire logic         timer1LowOverflow,
	input  wire logic         timer1SplitMode,
	input  wire logic         timer2Overflow,
	input  wire serial_mode_e serial0Mode,
	input  wire logic         serial0SyncDataOut,
	input  wire serial_mode_e serial1Mode,
	input  wire logic         serial1SyncDataOut,
	input  wire logic         waveformIfAddrBit8,
	// requests to the core
	output logic              extIrqSixRequest,
	output logic              timer2ReloadStrobe,
	output logic              irq
);

	// ======================================================
	// register decode, shared by write and read paths
	function automatic reg_sel_e decodeReg(input logic [7:0] addr);
		case (addr)
			`OFF_PORT_DATA:  decodeReg = SEL_DATA;
			`OFF_PORT_DIR:   decodeReg = SEL_DIR;
			`OFF_ALT_SELECT: decodeReg = SEL_ALT;
			`OFF_PIN_STATE:  decodeReg = SEL_PIN;
			`OFF_T2_CONTROL: decodeReg = SEL_T2CTL;
			`OFF_IRQ_STATUS: decodeReg = SEL_STATUS;
			`OFF_IRQ_CLEAR:  decodeReg = SEL_CLEAR;
			`OFF_IRQ_ENABLE: decodeReg = SEL_ENABLE;
			default:         decodeReg = SEL_NONE;
		endcase
	endfunction

	// ======================================================
	// declarations
	byte_t       portData;
	byte_t       portDir;
	byte_t       port_alt_select;
	byte_t       timer2_control;
	logic [1:0]  irqStatus;
	logic [1:0]  irqEnable;
	logic        haveAw;
	logic        haveW;
	logic [7:0]  wrAddr;
	logic [31:0] wrData;
	logic        wrLane0;
	logic        commit;
	logic        next_haveAw;
	logic        next_haveW;
	logic        next_bvalid;
	logic        next_rvalid;
	reg_sel_e    wrSel;
	reg_sel_e    rdSel;
	logic        wrByte;
	logic        timer0_overflow_pulse;
	logic        timer1_overflow_pulse;
	logic        timer2_overflow_pulse;
	logic        serial0Pin;
	logic        serial1Pin;
	logic        irqSixEdge;
	logic        reloadEdge;
	logic [1:0]  irqEvents;
	byte_t       next_pinOut;
	byte_t       next_pinOe;
	logic [31:0] next_rdata;

	pin_event_if pinEv ();

	// ======================================================
	// pin synchroniser and timer overflow pulse shapers
	pin_sync_edge u_sync (
		.ref_clk (ref_clk),
		.rst     (rst),
		.pinIn   (pinIn),
		.ev      (pinEv)
	);

	overflow_pulse_gen u_t0 (
		.ref_clk      (ref_clk),
		.rst          (rst),
		.overflowFull (timer0Overflow),
		.overflowLow  (timer0LowOverflow),
		.splitMode    (timer0SplitMode),
		.pulse        (timer0_overflow_pulse)
	);

	overflow_pulse_gen u_t1 (
		.ref_clk      (ref_clk),
		.rst          (rst),
		.overflowFull (timer1Overflow),
		.overflowLow  (timer1LowOverflow),
		.splitMode    (timer1SplitMode),
		.pulse        (timer1_overflow_pulse)
	);

	// timer 2 has no split mode, so the low input is unused
	overflow_pulse_gen u_t2 (
		.ref_clk      (ref_clk),
		.rst          (rst),
		.overflowFull (timer2Overflow),
		.overflowLow  (1'h0),
		.splitMode    (1'h0),
		.pulse        (timer2_overflow_pulse)
	);

	// ======================================================
	// write channel: address and data taken in either order
	assign commit  = haveAw & haveW & ~bvalid;
	assign wrSel   = decodeReg(wrAddr);
	assign wrByte  = commit & wrLane0;

	always_comb begin
		next_haveAw = haveAw | (awvalid & awready);
		next_haveW  = haveW | (wvalid & wready);
		next_bvalid = bvalid & ~bready;
		if (commit) begin
			next_haveAw = 1'h0;
			next_haveW  = 1'h0;
			next_bvalid = 1'h1;
		end
	end

	// holding registers for the accepted address and data
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			haveAw  <= 1'h0;
			haveW   <= 1'h0;
			wrAddr  <= 8'h00;
			wrData  <= 32'h0000_0000;
			wrLane0 <= 1'h0;
		end else begin
			haveAw <= next_haveAw;
			haveW  <= next_haveW;
			if (awvalid && awready) begin
				wrAddr <= awaddr;
			end
			if (wvalid && wready) begin
				wrData  <= wdata;
				wrLane0 <= wstrb[0]; // upper lanes hold no bits
			end
		end
	end

	// ready drops while a word is held or the answer waits
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			awready <= 1'h0;
			wready  <= 1'h0;
			bvalid  <= 1'h0;
			bresp   <= `RESP_OKAY;
		end else begin
			awready <= ~next_haveAw & ~next_bvalid;
			wready  <= ~next_haveW & ~next_bvalid;
			bvalid  <= next_bvalid;
			if (commit) begin
				bresp <= (wrSel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
			end
		end
	end

	// ======================================================
	// software registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			portData <= `RST_PORT_DATA;
			portDir  <= `RST_PORT_DIR;
		end else if (wrByte) begin
			if (wrSel == SEL_DATA) begin
				portData <= wrData[7:0];
			end
			if (wrSel == SEL_DIR) begin
				portDir <= wrData[7:0];
			end
		end
	end

	// alternate selection comes up as plain I/O
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			port_alt_select <= `RST_ALT_SELECT;
		end else if (wrByte && wrSel == SEL_ALT) begin
			port_alt_select <= wrData[7:0];
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			timer2_control <= `RST_T2_CONTROL;
			irqEnable      <= `RST_IRQ;
		end else if (wrByte) begin
			if (wrSel == SEL_T2CTL) begin
				timer2_control <= wrData[7:0];
			end
			if (wrSel == SEL_ENABLE) begin
				irqEnable <= wrData[1:0];
			end
		end
	end

	// ======================================================
	// input functions: edges only count when the pin is
	// given over to its alternate function
	assign irqSixEdge = port_alt_select[`PIN_EXT_IRQ6]
		& pinEv.rise[`PIN_EXT_IRQ6];
	assign reloadEdge = port_alt_select[`PIN_T2_RELOAD]
		& timer2_control[`T2CTL_EXT_EN]
		& pinEv.fall[`PIN_T2_RELOAD];

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			extIrqSixRequest   <= 1'h0;
			timer2ReloadStrobe <= 1'h0;
		end else begin
			extIrqSixRequest   <= irqSixEdge;
			timer2ReloadStrobe <= reloadEdge;
		end
	end

	// ======================================================
	// sticky status; a new event beats a clear in the same cycle
	assign irqEvents[`IRQ_EXT6_EDGE] = irqSixEdge;
	assign irqEvents[`IRQ_T2_RELOAD] = reloadEdge;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irqStatus <= `RST_IRQ;
		end else if (wrByte && wrSel == SEL_CLEAR) begin
			irqStatus <= (irqStatus & ~wrData[1:0]) | irqEvents;
		end else begin
			irqStatus <= irqStatus | irqEvents;
		end
	end

	// level output, one cycle behind the status it reflects
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irq <= 1'h0;
		end else begin
			irq <= |(irqStatus & irqEnable);
		end
	end

	// ======================================================
	// output pin mux
	assign serial0Pin = (serial0Mode == SER_MODE0)
		? serial0SyncDataOut : 1'h1;
	assign serial1Pin = (serial1Mode == SER_MODE0)
		? serial1SyncDataOut : 1'h1;

	always_comb begin
		// plain I/O everywhere first, then alternates override
		next_pinOut = portData;
		next_pinOe  = portDir;
		if (port_alt_select[`PIN_T0_OVF]) begin
			next_pinOut[`PIN_T0_OVF] = timer0_overflow_pulse;
			next_pinOe[`PIN_T0_OVF]  = 1'h1;
		end
		if (port_alt_select[`PIN_T1_OVF]) begin
			next_pinOut[`PIN_T1_OVF] = timer1_overflow_pulse;
			next_pinOe[`PIN_T1_OVF]  = 1'h1;
		end
		if (port_alt_select[`PIN_T2_OVF]) begin
			next_pinOut[`PIN_T2_OVF] = timer2_overflow_pulse;
			next_pinOe[`PIN_T2_OVF]  = 1'h1;
		end
		if (port_alt_select[`PIN_SER0_DATA]) begin
			next_pinOut[`PIN_SER0_DATA] = serial0Pin;
			next_pinOe[`PIN_SER0_DATA]  = 1'h1;
		end
		if (port_alt_select[`PIN_SER1_DATA]) begin
			next_pinOut[`PIN_SER1_DATA] = serial1Pin;
			next_pinOe[`PIN_SER1_DATA]  = 1'h1;
		end
		// the two input functions keep their drivers off
		if (port_alt_select[`PIN_EXT_IRQ6]) begin
			next_pinOut[`PIN_EXT_IRQ6] = 1'h0;
			next_pinOe[`PIN_EXT_IRQ6]  = 1'h0;
		end
		if (port_alt_select[`PIN_T2_RELOAD]) begin
			next_pinOut[`PIN_T2_RELOAD] = 1'h0;
			next_pinOe[`PIN_T2_RELOAD]  = 1'h0;
		end
		if (port_alt_select[`PIN_WAVE_ADDR8]) begin
			next_pinOut[`PIN_WAVE_ADDR8] = waveformIfAddrBit8;
			next_pinOe[`PIN_WAVE_ADDR8]  = 1'h1;
		end
	end

	// registered pins: glitch-free, at the cost of one cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pinOut <= 8'h00;
			pinOe  <= 8'h00;
		end else begin
			pinOut <= next_pinOut;
			pinOe  <= next_pinOe;
		end
	end

	// ======================================================
	// read channel, one word in flight
	assign rdSel       = decodeReg(araddr);
	assign next_rvalid = (arvalid & arready) | (rvalid & ~rready);

	always_comb begin
		next_rdata = 32'h0000_0000;
		case (rdSel)
			SEL_DATA:   next_rdata[7:0] = portData;
			SEL_DIR:    next_rdata[7:0] = portDir;
			SEL_ALT:    next_rdata[7:0] = port_alt_select;
			SEL_PIN:    next_rdata[7:0] = pinEv.level;
			SEL_T2CTL:  next_rdata[7:0] = timer2_control;
			SEL_STATUS: next_rdata[1:0] = irqStatus;
			SEL_ENABLE: next_rdata[1:0] = irqEnable;
			default:    next_rdata = 32'h0000_0000; // clear reads zero
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			arready <= 1'h0;
			rvalid  <= 1'h0;
			rdata   <= 32'h0000_0000;
			rresp   <= `RESP_OKAY;
		end else begin
			arready <= ~next_rvalid;
			rvalid  <= next_rvalid;
			if (arvalid && arready) begin
				rdata <= next_rdata;
				rresp <= (rdSel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
			end
		end
	end

endmodule

// [rtl/port_e_params.svh]
`ifndef PORT_E_PARAMS_SVH
`define PORT_E_PARAMS_SVH

// ==========================================================
// register byte offsets
`define OFF_PORT_DATA     8'h00
`define OFF_PORT_DIR      8'h04
`define OFF_ALT_SELECT    8'h08
`define OFF_PIN_STATE     8'h0C
`define OFF_T2_CONTROL    8'h10
`define OFF_IRQ_STATUS    8'h14
`define OFF_IRQ_CLEAR     8'h18
`define OFF_IRQ_ENABLE    8'h1C

// ==========================================================
// reset values
`define RST_PORT_DATA     8'h00
`define RST_PORT_DIR      8'h00
`define RST_ALT_SELECT    8'h00
`define RST_T2_CONTROL    8'h00
`define RST_IRQ           2'h0

// ==========================================================
// field positions
`define PIN_T0_OVF        0
`define PIN_T1_OVF        1
`define PIN_T2_OVF        2
`define PIN_SER0_DATA     3
`define PIN_SER1_DATA     4
`define PIN_EXT_IRQ6      5
`define PIN_T2_RELOAD     6
`define PIN_WAVE_ADDR8    7
`define T2CTL_EXT_EN      0
`define IRQ_EXT6_EDGE     0
`define IRQ_T2_RELOAD     1

// ==========================================================
// bus answers
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// [rtl/port_e_pkg.sv]
package port_e_pkg;

	// ======================================================
	// shared types
	typedef logic [7:0] byte_t;

	typedef enum logic [1:0] {
		SER_MODE0,
		SER_MODE1,
		SER_MODE2,
		SER_MODE3
	} serial_mode_e;

	typedef enum {
		SEL_DATA,
		SEL_DIR,
		SEL_ALT,
		SEL_PIN,
		SEL_T2CTL,
		SEL_STATUS,
		SEL_CLEAR,
		SEL_ENABLE,
		SEL_NONE
	} reg_sel_e;

endpackage

// [sim/pin_board_model.sv]
`timescale 1ns/100ps
// ==========================================================
// board logic on the port pins, pull-ups where nobody drives
module pin_board_model
	import port_e_pkg::*;
(
	input  wire byte_t pinOut,
	input  wire byte_t pinOe,
	input  wire byte_t boardEn,
	input  wire byte_t boardVal,
	output byte_t      pinIn
);
	// requests reach pin 5 as low-to-high moves of boardVal
	assign pinIn = (pinOe & pinOut) | (~pinOe & boardEn & boardVal) | (~pinOe & ~boardEn);
endmodule

// [sim/port_e_alt_function_mux_monitor.sv]
`timescale 1ns/100ps
// ==========================================================
// pin-level checker, sees only the mux ports
module port_e_alt_function_mux_monitor
	import port_e_pkg::*;
(
	input wire logic         ref_clk,
	input wire logic         rst,
	input wire logic [7:0]   awaddr,
	input wire logic         awvalid,
	input wire logic         awready,
	input wire logic [31:0]  wdata,
	input wire logic         wvalid,
	input wire logic         wready,
	input wire logic         bvalid,
	input wire logic         bready,
	input wire byte_t        pinIn,
	input wire byte_t        pinOut,
	input wire byte_t        pinOe,
	input wire logic         timer0Overflow,
	input wire logic         timer0LowOverflow,
	input wire logic         timer0SplitMode,
	input wire logic         timer2Overflow,
	input wire serial_mode_e serial0Mode,
	input wire logic         serial0SyncDataOut,
	input wire serial_mode_e serial1Mode,
	input wire logic         serial1SyncDataOut,
	input wire logic         waveformIfAddrBit8,
	input wire logic         extIrqSixRequest,
	input wire logic         timer2ReloadStrobe
);
	byte_t      addr, data, altSel, h5, h6;
	logic [1:0] quiet;
	logic       src0;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// ==========================================================
	// helpers: bus snoop and pin history
	always_ff @(posedge ref_clk) begin
		if (awvalid && awready)
			addr <= awaddr;
		if (wvalid && wready)
			data <= wdata[7:0];
		h5 <= {h5[6:0], pinIn[5]};
		h6 <= {h6[6:0], pinIn[6]};
	end
	// outputs trail the select by a cycle, so judge only once settled
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			altSel <= 8'h00;
			quiet  <= 2'h0;
		end else begin
			if (bvalid && bready && addr == 8'h08)
				altSel <= data;
			quiet <= bvalid ? 2'h0 : (quiet == 2'h3 ? quiet : quiet + 2'h1);
		end
	end
	assign src0 = timer0SplitMode ? timer0LowOverflow : timer0Overflow;

	// ==========================================================
	// properties
	sequence s_one(b);
		b ##1 !b;
	endsequence
	sequence s_rise5;
		|(h5[4:2] & ~h5[5:3]);
	endsequence
	sequence s_fall6;
		|(~h6[4:2] & h6[5:3]);
	endsequence
	property p_t0;
		quiet == 2'h3 && altSel[0] && $rose(src0) |-> ##2 s_one(pinOut[0]);
	endproperty
	a_t0: assert property (p_t0) else $error("timer0 pin pulse wrong");
	property p_t2;
		quiet == 2'h3 && altSel[2] && $rose(timer2Overflow) |-> ##2 s_one(pinOut[2]);
	endproperty
	a_t2: assert property (p_t2) else $error("timer2 pin pulse wrong");
	property p_ser0;
		quiet == 2'h3 && altSel[3] |-> pinOe[3]
			&& pinOut[3] == ($past(serial0Mode) != SER_MODE0 || $past(serial0SyncDataOut));
	endproperty
	a_ser0: assert property (p_ser0) else $error("serial0 pin wrong");
	property p_ser1;
		quiet == 2'h3 && altSel[4] |-> pinOe[4]
			&& pinOut[4] == ($past(serial1Mode) != SER_MODE0 || $past(serial1SyncDataOut));
	endproperty
	a_ser1: assert property (p_ser1) else $error("serial1 pin wrong");
	property p_wave;
		quiet == 2'h3 && altSel[7] |-> pinOe[7] && pinOut[7] == $past(waveformIfAddrBit8);
	endproperty
	a_wave: assert property (p_wave) else $error("address pin wrong");
	property p_irq6;
		extIrqSixRequest |-> s_rise5 ##1 !extIrqSixRequest;
	endproperty
	a_irq6: assert property (p_irq6) else $error("irq six request wrong");
	property p_reload;
		timer2ReloadStrobe |-> s_fall6 ##1 !timer2ReloadStrobe;
	endproperty
	a_reload: assert property (p_reload) else $error("reload strobe wrong");
	property p_reset;
		$fell(rst) |-> pinOe == 8'h00 [*4];
	endproperty
	a_reset: assert property (p_reset) else $error("pins driven after reset");
endmodule

bind port_e_alt_function_mux port_e_alt_function_mux_monitor mon (.*);

// [sim/port_e_alt_function_mux_tb.sv]
`timescale 1ns/100ps
module port_e_alt_function_mux_tb
	import port_e_pkg::*;
;
	logic         ref_clk = 1'h0;
	logic         rst = 1'h1;
	logic [7:0]   awaddr = 8'h00;
	logic [7:0]   araddr = 8'h00;
	logic [31:0]  wdata = 32'h0;
	logic [3:0]   wstrb = 4'h0;
	logic         awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic         awready, wready, bvalid, arready, rvalid, irq;
	logic         extIrqSixRequest, timer2ReloadStrobe;
	logic [1:0]   bresp, rresp;
	logic [31:0]  rdata;
	byte_t        pinIn, pinOut, pinOe, dir, dat, r, n;
	byte_t        bEn = 8'h00, bVal = 8'h00;
	logic [4:0]   ovf = 5'h00;
	logic [1:0]   spl = 2'h0;
	serial_mode_e serial0Mode = SER_MODE0, serial1Mode = SER_MODE0;
	logic         serial0SyncDataOut = 1'h0, serial1SyncDataOut = 1'h0, waveformIfAddrBit8 = 1'h0;
	logic [33:0]  q[$];
	int           numErrors = 0, samplesChecked = 0, n6 = 0, nrl = 0;

	port_e_alt_function_mux dut (
		.timer0Overflow   (ovf[0]),
		.timer0LowOverflow(ovf[1]),
		.timer0SplitMode  (spl[0]),
		.timer1Overflow   (ovf[2]),
		.timer1LowOverflow(ovf[3]),
		.timer1SplitMode  (spl[1]),
		.timer2Overflow   (ovf[4]),
		.*
	);
	pin_board_model board (.pinOut(pinOut), .pinOe(pinOe), .boardEn(bEn), .boardVal(bVal),
		.pinIn(pinIn));

	always #5 ref_clk = ~ref_clk;

	// ==========================================================
	// scoreboard and shared checks
	task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
		samplesChecked++;
		if (got !== exp) begin
			numErrors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// oldest note against each bus answer
	always @(posedge ref_clk) begin
		if (rvalid && rready)
			cmp({rresp, rdata}, q.pop_front());
		if (bvalid && bready)
			cmp({bresp, 32'h0}, q.pop_front());
	end
	// request pulses counted as they appear
	always @(posedge ref_clk) begin
		n6 += extIrqSixRequest;
		nrl += timer2ReloadStrobe;
	end
	task automatic pins(input byte_t m, input byte_t oe, input byte_t o);
		cmp({18'h0, pinOe, pinOut & m}, {18'h0, oe, o});
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge ref_clk);
	endtask

	// ==========================================================
	// bus master; each channel held until its own handshake
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		q.push_back({e, 32'h0});
		@(posedge ref_clk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= 4'hF;
		awvalid <= 1'h1;
		wvalid  <= 1'h1;
		bready  <= 1'h1;
		do begin
			@(posedge ref_clk);
			if (awready)
				awvalid <= 1'h0;
			if (wready)
				wvalid <= 1'h0;
		end while (!bvalid);
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		q.push_back(e);
		@(posedge ref_clk);
		araddr  <= a;
		arvalid <= 1'h1;
		rready  <= 1'h1;
		do begin
			@(posedge ref_clk);
			if (arready)
				arvalid <= 1'h0;
		end while (!rvalid);
		rready <= 1'h0;
	endtask

	task automatic endSim();
		$display("checks %0d mismatches %0d", samplesChecked, numErrors);
		if (numErrors == 0 && samplesChecked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(95));
		tick(2);
		rst <= 1'h0;
		for (int a = 0; a < 32; a += 4)
			rd(8'(a), {26'h0, a == 12 ? 8'hFF : 8'h00});
		rd(8'h20, {2'h2, 32'h0});
		wr(8'h24, 32'h1, 2'h2);
		pins(8'h00, 8'h00, 8'h00);
		$display("test reset done");
		// board drives some undriven pins low, the rest float to the pull-up
		repeat (4) begin
			dir = $urandom;
			dat = $urandom;
			r = $urandom;
			bEn <= ~dir & r;
			wr(8'h04, {24'h0, dir}, 2'h0);
			wr(8'h00, {24'h0, dat}, 2'h0);
			tick(4);
			pins(dir, dir, dir & dat);
			rd(8'h0C, {26'h0, (dir & dat) | (~dir & ~r)});
			rd(8'h04, {26'h0, dir});
		end
		$display("test plain io done");
		wr(8'h04, 32'h0, 2'h0);
		wr(8'h08, 32'hF8, 2'h0);
		for (int m = 0; m < 4; m++) begin
			r = $urandom;
			serial0Mode <= serial_mode_e'(2'(m));
			serial1Mode <= serial_mode_e'(2'(3 - m));
			serial0SyncDataOut <= r[0];
			serial1SyncDataOut <= r[1];
			waveformIfAddrBit8 <= r[2];
			tick(3);
			pins(8'h98, 8'h98, {r[2], 2'h0, m == 3 ? r[1] : 1'h1, m == 0 ? r[0] : 1'h1, 3'h0});
		end
		$display("test serial done");
		// selected overflow held high for many cycles must still give one pulse, the unselected one none
		wr(8'h08, 32'h07, 2'h0);
		for (int k = 0; k < 9; k++) begin
			spl <= {k[1], k[1]};
			tick(2);
			ovf[k == 8 ? 4 : 2 * (k / 4) + k[0]] <= 1'h1;
			n = 8'h00;
			repeat (8) begin
				@(posedge ref_clk);
				n = n + pinOut[k / 4];
			end
			ovf <= 5'h00;
			cmp({26'h0, n}, {33'h0, k == 8 || k[1] == k[0]});
		end
		$display("test timers done");
		bEn <= 8'h60;
		bVal <= 8'h40;
		wr(8'h1C, 32'h3, 2'h0);
		wr(8'h08, 32'h60, 2'h0);
		tick(6);
		bVal <= 8'h00;
		tick(6);
		rd(8'h14, 34'h0);
		wr(8'h10, 32'h1, 2'h0);
		bVal <= 8'h40;
		tick(6);
		bVal <= 8'h20;
		tick(6);
		bVal <= 8'h00;
		tick(6);
		cmp({2'h0, n6[15:0], nrl[15:0]}, {18'h1, 16'h1});
		rd(8'h14, 34'h3);
		cmp({33'h0, irq}, 34'h1);
		wr(8'h1C, 32'h0, 2'h0);
		tick(2);
		cmp({33'h0, irq}, 34'h0);
		wr(8'h1C, 32'h3, 2'h0);
		wr(8'h18, 32'h3, 2'h0);
		tick(2);
		rd(8'h14, 34'h0);
		cmp({33'h0, irq}, 34'h0);
		$display("test irq done");
		endSim();
	end

	// hang guard, well past the few hundred cycles the tests need
	initial begin
		#300000;
		numErrors++;
		endSim();
	end
endmodule
